/* File: gpin_pkg.sv */
//==========================================================
// shared constants and types of the general pin block
//==========================================================
package gpin_pkg;

	// register addresses on the management port
	localparam logic [7:0] PIN1_CONFIG_ADDR = 8'h03;
	localparam logic [7:0] PIN2_CONFIG_ADDR = 8'h04;
	localparam logic [7:0] PIN_INPUT_READBACK_ADDR = 8'h05;
	localparam logic [7:0] PIN_OUTPUT_VALUE_ADDR = 8'h06;

	// field positions inside a pin configuration byte
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 4;
	localparam int PULL_MSB = 3;
	localparam int PULL_LSB = 2;
	localparam int IBUF_BIT = 1;
	localparam int DRIVE_BIT = 0;

	// pull selection codes
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;

	// pin 1 function codes
	localparam logic [3:0] M1_POR = 4'h0;
	localparam logic [3:0] M1_OUTREG = 4'h1;
	localparam logic [3:0] M1_PLL_LOCK = 4'h2;
	localparam logic [3:0] M1_LOS_FIRST = 4'h4;
	localparam logic [3:0] M1_LOS_LAST = 4'h8;

	// pin 2 function codes
	localparam logic [3:0] M2_OUTREG = 4'h0;
	localparam logic [3:0] M2_HIGH = 4'h1;
	localparam logic [3:0] M2_SER_CLK = 4'h2;
	localparam logic [3:0] M2_PAR_CLK = 4'h3;
	localparam logic [3:0] M2_HOST_CLK = 4'h4;

	// one pin configuration byte
	typedef struct packed {
		logic [3:0] mode;
		logic [1:0] pull;
		logic ibuf_en;
		logic drive_en;
	} pin_cfg_t;

	// reset values
	localparam pin_cfg_t PIN1_CONFIG_RST = '{mode: 4'h0, pull: PULL_DOWN, ibuf_en: 1'b0,
		drive_en: 1'b1};
	localparam pin_cfg_t PIN2_CONFIG_RST = '{mode: 4'h0, pull: PULL_DOWN, ibuf_en: 1'b0,
		drive_en: 1'b0};
	localparam logic [2:0] OUTPUT_VALUE_RST = 3'h0;
	localparam int NUM_PINS = 3;
	localparam int NUM_LANES = 5;

endpackage

/* File: gpin_sync.sv */
`timescale 1ns/100ps
//==========================================================
// two flop synchroniser for pad inputs
//==========================================================
module gpin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [WIDTH-1:0] async_in, // level from the pads
	output logic [WIDTH-1:0] sync_out // level in the clock domain
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

/* File: gpin_core.sv */
`timescale 1ns/100ps
// Summary of operation
// - pin 1 function: 0 reset, 1 output register, 2 pll lock, 4-8 lane loss
// - pin 2 function: 0 output register, 1 high, 2 bit clock, 3 parallel, 4 host
// - bits 3:2 pick pull: none, pulldown at reset, pullup; 11 reserved
// - bit 1 enables the pin input buffer, disabled after reset
// - bit 0 enables the driver; pin 1 drives after reset, pin 2 floats
// - input readback returns pin levels 0..2 in bits 0..2, pins 1 and 2 read zero with buffer off, upper bits zero
// - writes to the output value reach pins set as general outputs
// - output value bits 0..2 feed pins 0..2, read/write, reset zero
module gpin_core (
	input wire logic SYS_CLK, // 100 MHz system clock
	input wire logic NRST, // async reset, active low
	input wire logic REG_WR, // register write strobe
	input wire logic REG_RD, // register read strobe
	input wire logic [7:0] REG_ADDR, // register address
	input wire logic [7:0] REG_WDATA, // register write data
	output logic [7:0] REG_RDATA, // registered read data
	input wire logic POR_IN, // internal power-on reset level
	input wire logic PLL_LOCK, // internal pll lock
	input wire logic [4:0] LANE_LOS, // lane_signal_loss flags per lane
	input wire logic SER_CLK_IN, // serializer bit clock copy
	input wire logic PAR_CLK_IN, // parallel clock copy
	input wire logic HOST_CLK_IN, // digital copy of host_ddr_clock
	input wire logic [2:0] PIN_I, // pad levels of pins 0..2
	output logic PIN0_OUT_VALUE, // output value bit for pin 0
	output logic PIN1_O, // pin 1 output level
	output logic PIN1_OE, // pin 1 output enable
	output logic [1:0] PIN1_PULL, // pin 1 pull select
	output logic PIN1_IBUF_EN, // pin 1 input buffer enable
	output logic PIN2_O, // pin 2 output level
	output logic PIN2_OE, // pin 2 output enable
	output logic [1:0] PIN2_PULL, // pin 2 pull select
	output logic PIN2_IBUF_EN // pin 2 input buffer enable
);
	gpin_pkg::pin_cfg_t cfg1_q;
	gpin_pkg::pin_cfg_t cfg1_d;
	gpin_pkg::pin_cfg_t cfg2_q;
	gpin_pkg::pin_cfg_t cfg2_d;
	logic [2:0] outval_q;
	logic [2:0] outval_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic pin1_q;
	logic pin1_d;
	logic pin2_q;
	logic pin2_d;
	logic [2:0] pin_sync;
	logic [2:0] readback;

	//==========================================================
	// pad input synchroniser
	//==========================================================
	gpin_sync #(
		.WIDTH(gpin_pkg::NUM_PINS)
	) u_sync (
		.clk(SYS_CLK),
		.nrst(NRST),
		.async_in(PIN_I),
		.sync_out(pin_sync)
	);

	//==========================================================
	// register file
	//==========================================================
	// readback masks pins whose input buffer is off
	always_comb begin
		readback[0] = pin_sync[0];
		readback[1] = pin_sync[1] & cfg1_q.ibuf_en;
		readback[2] = pin_sync[2] & cfg2_q.ibuf_en;
	end

	// write decode and read mux
	always_comb begin
		cfg1_d = cfg1_q;
		cfg2_d = cfg2_q;
		outval_d = outval_q;
		rdata_d = rdata_q;
		if (REG_WR) begin
			unique case (REG_ADDR)
				gpin_pkg::PIN1_CONFIG_ADDR: cfg1_d = gpin_pkg::pin_cfg_t'(REG_WDATA);
				gpin_pkg::PIN2_CONFIG_ADDR: cfg2_d = gpin_pkg::pin_cfg_t'(REG_WDATA);
				gpin_pkg::PIN_OUTPUT_VALUE_ADDR: outval_d = REG_WDATA[2:0];
				default: ;
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				gpin_pkg::PIN1_CONFIG_ADDR: rdata_d = cfg1_q;
				gpin_pkg::PIN2_CONFIG_ADDR: rdata_d = cfg2_q;
				gpin_pkg::PIN_INPUT_READBACK_ADDR: rdata_d = {5'h00, readback};
				gpin_pkg::PIN_OUTPUT_VALUE_ADDR: rdata_d = {5'h00, outval_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			cfg1_q <= gpin_pkg::PIN1_CONFIG_RST;
			cfg2_q <= gpin_pkg::PIN2_CONFIG_RST;
			outval_q <= gpin_pkg::OUTPUT_VALUE_RST;
			rdata_q <= 8'h00;
		end else begin
			cfg1_q <= cfg1_d;
			cfg2_q <= cfg2_d;
			outval_q <= outval_d;
			rdata_q <= rdata_d;
		end
	end

	//==========================================================
	// pin function multiplexers
	//==========================================================
	// pin 1 source select, reserved codes give low
	always_comb begin
		pin1_d = 1'b0;
		if (cfg1_q.mode == gpin_pkg::M1_POR) begin
			pin1_d = POR_IN;
		end else if (cfg1_q.mode == gpin_pkg::M1_OUTREG) begin
			pin1_d = outval_q[1];
		end else if (cfg1_q.mode == gpin_pkg::M1_PLL_LOCK) begin
			pin1_d = PLL_LOCK;
		end else if (cfg1_q.mode >= gpin_pkg::M1_LOS_FIRST &&
			cfg1_q.mode <= gpin_pkg::M1_LOS_LAST) begin
			pin1_d = LANE_LOS[3'(cfg1_q.mode - gpin_pkg::M1_LOS_FIRST)];
		end
	end

	// pin 2 source select, reserved codes give low
	always_comb begin
		pin2_d = 1'b0;
		unique case (cfg2_q.mode)
			gpin_pkg::M2_OUTREG: pin2_d = outval_q[2];
			gpin_pkg::M2_HIGH: pin2_d = 1'b1;
			gpin_pkg::M2_SER_CLK: pin2_d = SER_CLK_IN;
			gpin_pkg::M2_PAR_CLK: pin2_d = PAR_CLK_IN;
			gpin_pkg::M2_HOST_CLK: pin2_d = HOST_CLK_IN;
			default: pin2_d = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			pin1_q <= 1'b0;
			pin2_q <= 1'b0;
		end else begin
			pin1_q <= pin1_d;
			pin2_q <= pin2_d;
		end
	end

	// outputs straight from flops
	assign REG_RDATA = rdata_q;
	assign PIN0_OUT_VALUE = outval_q[0];
	assign PIN1_O = pin1_q;
	assign PIN2_O = pin2_q;
	assign PIN1_OE = cfg1_q.drive_en;
	assign PIN2_OE = cfg2_q.drive_en;
	assign PIN1_PULL = cfg1_q.pull;
	assign PIN2_PULL = cfg2_q.pull;
	assign PIN1_IBUF_EN = cfg1_q.ibuf_en;
	assign PIN2_IBUF_EN = cfg2_q.ibuf_en;

	//==========================================================
	// assertions
	//==========================================================
	a_pin1_pll: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(cfg1_q.mode == gpin_pkg::M1_PLL_LOCK) |=> (PIN1_O == $past(PLL_LOCK)))
		else $error("pin 1 does not follow pll lock");

	a_pin1_los: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(cfg1_q.mode == 4'h6) |=> (PIN1_O == $past(LANE_LOS[2])))
		else $error("pin 1 does not follow lane 2 loss");

	a_pin2_high: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(cfg2_q.mode == gpin_pkg::M2_HIGH) |=> PIN2_O)
		else $error("pin 2 not high in constant mode");

	a_pull_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR == gpin_pkg::PIN1_CONFIG_ADDR) |=>
		(PIN1_PULL == $past(REG_WDATA[3:2])))
		else $error("pin 1 pull not taken from write");

	a_ibuf_mask: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == gpin_pkg::PIN_INPUT_READBACK_ADDR && !PIN2_IBUF_EN) |=>
		!REG_RDATA[2])
		else $error("disabled input buffer seen in readback");

	a_drive_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR == gpin_pkg::PIN2_CONFIG_ADDR) |=>
		(PIN2_OE == $past(REG_WDATA[0])))
		else $error("pin 2 drive enable not taken from write");

	a_readback_top: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_RD && REG_ADDR == gpin_pkg::PIN_INPUT_READBACK_ADDR) |=>
		(REG_RDATA[7:3] == 5'h00 && REG_RDATA[0] == $past(pin_sync[0])))
		else $error("readback layout wrong");

	a_outreg_pin: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR == gpin_pkg::PIN_OUTPUT_VALUE_ADDR &&
		cfg1_q.mode == gpin_pkg::M1_OUTREG) ##1 (cfg1_q.mode == gpin_pkg::M1_OUTREG) |=>
		(PIN1_O == $past(REG_WDATA[1], 2)))
		else $error("output value not on pin 1");

	a_outval_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(REG_WR && REG_ADDR == gpin_pkg::PIN_OUTPUT_VALUE_ADDR) ##1
		(REG_RD && REG_ADDR == gpin_pkg::PIN_OUTPUT_VALUE_ADDR && !REG_WR) |=>
		(REG_RDATA == {5'h00, $past(REG_WDATA[2:0], 2)}))
		else $error("output value readback wrong");

	a_reserved_low: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		(cfg2_q.mode > gpin_pkg::M2_HOST_CLK) |=> !PIN2_O)
		else $error("reserved pin 2 function not low");

	c_pin1_los: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		cfg1_q.mode == gpin_pkg::M1_LOS_LAST ##1 PIN1_O);
	c_pin2_host: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		cfg2_q.mode == gpin_pkg::M2_HOST_CLK ##1 PIN2_O);
	c_readback: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		REG_RD && REG_ADDR == gpin_pkg::PIN_INPUT_READBACK_ADDR ##1 REG_RDATA[1]);
endmodule

/* File: pin_board.sv */
`timescale 1ns/100ps
//==========================================================
// board logic on the general pins
//==========================================================
module pin_board (
	input wire logic [1:0] drive, // device levels, pins 1 and 2
	input wire logic [1:0] drive_en, // device drive enables
	input wire logic [2:0] ext, // levels the board drives
	output logic [2:0] pad // resolved pad levels
);
	// pin 0 is board driven; a pin the device drives shows its level
	always_comb begin
		pad[0] = ext[0];
		pad[1] = drive_en[0] ? drive[0] : ext[1];
		pad[2] = drive_en[1] ? drive[1] : ext[2];
	end
endmodule

/* File: test_gpin_core.sv */
`timescale 1ns/100ps
//==========================================================
// bench for the general pin block
//==========================================================
module test_gpin_core;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic por = 1'b0;
	logic lock = 1'b0;
	logic ser = 1'b0;
	logic par = 1'b0;
	logic host = 1'b0;
	logic rsv;
	logic [4:0] los = 5'h00;
	logic [2:0] ext = 3'h0;
	logic [2:0] pad;
	logic p0v, p1o, p1oe, p1ib, p2o, p2oe, p2ib;
	logic [1:0] p1pl, p2pl;
	int failures = 0;
	int total_checks = 0;
	int m;
	// clock
	initial begin
		forever #5 clk = ~clk;
	end
	gpin_core DUT (.SYS_CLK(clk), .NRST(nrst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .POR_IN(por), .PLL_LOCK(lock),
		.LANE_LOS(los), .SER_CLK_IN(ser), .PAR_CLK_IN(par), .HOST_CLK_IN(host),
		.PIN_I(pad), .PIN0_OUT_VALUE(p0v), .PIN1_O(p1o), .PIN1_OE(p1oe),
		.PIN1_PULL(p1pl), .PIN1_IBUF_EN(p1ib), .PIN2_O(p2o), .PIN2_OE(p2oe),
		.PIN2_PULL(p2pl), .PIN2_IBUF_EN(p2ib));
	pin_board board (.drive({p2o, p1o}), .drive_en({p2oe, p1oe}), .ext(ext), .pad(pad));
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// register byte compare
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: reg %h want %h", $time, got, exp);
		end
	endtask
	// pin level or pull compare
	task automatic cmpl(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: pin %b want %b", $time, got, exp);
		end
	endtask
	// wait n edges, then settle at the falling edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// one register write
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one register read with expected byte
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp8(rdata, exp);
	endtask
	// write then read the same register on the next edge
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp8(rdata, exp);
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("mismatch at %0t: run too long", $time);
		conclude();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		tick(0);
		cmpl(p1oe, 2'h1);
		cmpl(p2oe, 2'h0);
		cmpl(p1pl, 2'h1);
		cmpl(p2pl, 2'h1);
		cmpl({p2ib, p1ib}, 2'h0);
		rreg(gpin_pkg::PIN1_CONFIG_ADDR, 8'h05);
		rreg(gpin_pkg::PIN2_CONFIG_ADDR, 8'h04);
		rreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, 8'h00);
		$display("end reset");
		// pin 1 codes 0 to 9, target source high; reserved with all high
		for (m = 0; m < 10; m++) begin
			@(posedge clk);
			rsv = (m == 3) || (m == 9);
			por <= rsv || m == 0;
			lock <= rsv || m == 2;
			los <= rsv ? 5'h1f : (m >= 4 ? 5'h01 << (m - 4) : 5'h00);
			wreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, {6'h00, rsv || m == 1, 1'b0});
			wreg(gpin_pkg::PIN1_CONFIG_ADDR, {m[3:0], 4'h5});
			tick(2);
			cmpl(p1o, !rsv);
		end
		$display("end pin1 modes");
		// pin 2 codes 0 to 5
		for (m = 0; m < 6; m++) begin
			@(posedge clk);
			rsv = (m == 5);
			ser <= rsv || m == 2;
			par <= rsv || m == 3;
			host <= rsv || m == 4;
			wreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, {5'h00, rsv || m == 0, 2'h0});
			wreg(gpin_pkg::PIN2_CONFIG_ADDR, {m[3:0], 4'h5});
			tick(2);
			cmpl(p2o, !rsv);
		end
		$display("end pin2 modes");
		// pull codes on both pins, pin 2 config read back
		for (m = 0; m < 4; m++) begin
			wreg(gpin_pkg::PIN1_CONFIG_ADDR, {4'h1, m[1:0], 2'h1});
			wreg(gpin_pkg::PIN2_CONFIG_ADDR, {4'h0, m[1:0], 2'h0});
			tick(0);
			cmpl(p1pl, m[1:0]);
			cmpl(p2pl, m[1:0]);
			rreg(gpin_pkg::PIN2_CONFIG_ADDR, {4'h0, m[1:0], 2'h0});
		end
		$display("end pulls");
		// pins as inputs: drive off, buffer on, then buffer off
		wreg(gpin_pkg::PIN1_CONFIG_ADDR, 8'h06);
		wreg(gpin_pkg::PIN2_CONFIG_ADDR, 8'h06);
		tick(0);
		cmpl({p2oe, p1oe}, 2'h0);
		cmpl({p2ib, p1ib}, 2'h3);
		@(posedge clk);
		ext <= 3'h5;
		tick(3);
		rreg(gpin_pkg::PIN_INPUT_READBACK_ADDR, 8'h05);
		@(posedge clk);
		ext <= 3'h2;
		tick(3);
		rreg(gpin_pkg::PIN_INPUT_READBACK_ADDR, 8'h02);
		wreg(gpin_pkg::PIN1_CONFIG_ADDR, 8'h04);
		wreg(gpin_pkg::PIN2_CONFIG_ADDR, 8'h04);
		@(posedge clk);
		ext <= 3'h7;
		tick(3);
		rreg(gpin_pkg::PIN_INPUT_READBACK_ADDR, 8'h01);
		$display("end readback");
		// read-only, unmapped and value register
		wreg(gpin_pkg::PIN_INPUT_READBACK_ADDR, 8'hff);
		wreg(8'h07, 8'hff);
		rreg(8'h07, 8'h00);
		rreg(gpin_pkg::PIN1_CONFIG_ADDR, 8'h04);
		wreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, 8'hff);
		tick(0);
		cmpl(p0v, 2'h1);
		rreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, 8'h07);
		wreg(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, 8'hfe);
		tick(0);
		cmpl(p0v, 2'h0);
		wrrd(gpin_pkg::PIN_OUTPUT_VALUE_ADDR, 8'h0a, 8'h02);
		$display("end access");
		conclude();
	end
endmodule
